// file: src/aoms_mode_sequencer.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "aoms_defs.svh"
module aoms_mode_sequencer #(
  parameter int unsigned DATA_W        = 24,
  parameter int unsigned SETTLE_CYCLES =
    (`AOMS_SYS_CLK_HZ / `AOMS_HZ_PER_MHZ) * `AOMS_OSC_SETTLE_US
)(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // axi4-lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // converter core
  input  wire logic [DATA_W-1:0] conv_result,
  output logic                   mod_reset,
  output logic                   filter_reset,
  output logic                   mod_clk_en,
  output logic                   analog_power_en,
  output logic                   excitation_en,
  output logic                   burnout_en,
  output logic                   bias_en,
  output logic                   clock_output_driver,
  output logic [2:0]             channel_sel,
  // serial pins and ready
  input  wire logic              ser_clk,
  output logic                   ser_dout,
  output logic                   conv_ready_n,
  // interrupt
  output logic                   irq
);
  localparam int unsigned DIV   = `AOMS_SYS_CLK_HZ / `AOMS_MOD_CLK_HZ;
  localparam int unsigned DIV_W = $clog2(DIV);
  localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `AOMS_OFF_MODE || a == `AOMS_OFF_CFG || a == `AOMS_OFF_IO ||
           a == `AOMS_OFF_DATA || a == `AOMS_OFF_STAT ||
           a == `AOMS_OFF_INT_STAT || a == `AOMS_OFF_INT_MASK ||
           a == `AOMS_OFF_RATE || a == `AOMS_OFF_CTRL;
  endfunction

  // bus state
  logic        aw_have_reg, aw_have_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_have_reg,  w_have_next;
  logic [31:0] w_data_reg,  w_data_next;
  logic [3:0]  w_strb_reg,  w_strb_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  // core state
  aoms_pkg::aoms_state_e state_reg, state_next;
  logic [15:0]       mode_reg,   mode_next;
  logic [15:0]       cfg_reg,    cfg_next;
  logic [15:0]       io_reg,     io_next;
  logic [15:0]       rate_reg,   rate_next;
  logic              cread_reg,  cread_next;
  logic [1:0]        ist_reg,    ist_next;
  logic [1:0]        imask_reg,  imask_next;
  logic [DATA_W-1:0] result_reg, result_next;
  logic              rdy_n_reg,  rdy_n_next;
  logic              first_reg,  first_next;
  logic [16:0]       cnt_reg,    cnt_next;
  logic [SET_W-1:0]  set_reg,    set_next;
  logic [DIV_W-1:0]  div_reg,    div_next;
  logic              mrst_reg,   mrst_next;

  logic        wr_fire, ar_fire, rd_data_fire, tick, converting;
  logic        restart, mode_wr, conv_done;
  logic [31:0] wr_img, rd_mux;
  logic [2:0]  new_mode;

  aoms_shift_if #(.DATA_W(DATA_W)) sh ();

  // both write channels are latched independently, so either may come first
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_fire       = aw_have_reg && w_have_reg && !bvalid_reg;
  assign ar_fire       = s_axi_arvalid && !rvalid_reg;
  assign rd_data_fire  = ar_fire && s_axi_araddr == `AOMS_OFF_DATA;

  // read image of the register file
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      `AOMS_OFF_MODE:     rd_mux = {16'h0, mode_reg};
      `AOMS_OFF_CFG:      rd_mux = {16'h0, cfg_reg};
      `AOMS_OFF_IO:       rd_mux = {16'h0, io_reg};
      `AOMS_OFF_DATA:     rd_mux = 32'(result_reg);
      `AOMS_OFF_STAT:     rd_mux = {27'h0, first_reg, state_reg, rdy_n_reg};
      `AOMS_OFF_INT_STAT: rd_mux = {30'h0, ist_reg};
      `AOMS_OFF_INT_MASK: rd_mux = {30'h0, imask_reg};
      `AOMS_OFF_RATE:     rd_mux = {16'h0, rate_reg};
      `AOMS_OFF_CTRL:     rd_mux = {31'h0, cread_reg};
      default:            rd_mux = 32'h0;
    endcase
  end

  // bus channel next values
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_mapped(aw_addr_reg) ? `AOMS_RESP_OKAY
                                            : `AOMS_RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (ar_fire) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_mux;
      rresp_next  = is_mapped(s_axi_araddr) ? `AOMS_RESP_OKAY
                                            : `AOMS_RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AOMS_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `AOMS_RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // write decode; channel change arrives through the configuration write
  assign wr_img   = aoms_pkg::aoms_merge(32'h0 | w_data_reg, w_data_reg,
                                         w_strb_reg);
  assign mode_wr  = wr_fire && aw_addr_reg == `AOMS_OFF_MODE;
  assign restart  = mode_wr || (wr_fire && (aw_addr_reg == `AOMS_OFF_CFG ||
                    aw_addr_reg == `AOMS_OFF_IO));
  assign tick     = div_reg == DIV_W'(DIV - 1);
  assign converting = state_reg == aoms_pkg::AOMS_ST_CONT ||
                      state_reg == aoms_pkg::AOMS_ST_SINGLE;
  // idle and power-down never reach here, so they yield nothing
  assign conv_done = tick && converting && !restart &&
                     cnt_reg == aoms_pkg::aoms_last_tick(rate_reg, first_reg);

  // sequencer and register file
  always_comb begin
    state_next  = state_reg;
    mode_next   = mode_reg;
    cfg_next    = cfg_reg;
    io_next     = io_reg;
    rate_next   = rate_reg;
    cread_next  = cread_reg;
    imask_next  = imask_reg;
    result_next = result_reg;
    first_next  = first_reg;
    cnt_next    = cnt_reg;
    set_next    = set_reg;
    div_next    = tick ? '0 : div_reg + 1'b1;
    ist_next    = ist_reg;
    rdy_n_next  = rdy_n_reg;
    new_mode    = mode_reg[`AOMS_MODE_HI:`AOMS_MODE_LO];
    // register writes, merged lane by lane
    if (wr_fire) begin
      unique case (aw_addr_reg)
        `AOMS_OFF_MODE: begin
          mode_next = 16'(aoms_pkg::aoms_merge({16'h0, mode_reg}, w_data_reg,
                                               w_strb_reg));
          new_mode  = mode_next[`AOMS_MODE_HI:`AOMS_MODE_LO];
        end
        `AOMS_OFF_CFG: cfg_next = 16'(aoms_pkg::aoms_merge({16'h0, cfg_reg},
                                      w_data_reg, w_strb_reg));
        `AOMS_OFF_IO: io_next = 16'(aoms_pkg::aoms_merge({16'h0, io_reg},
                                    w_data_reg, w_strb_reg));
        `AOMS_OFF_RATE: rate_next = 16'(aoms_pkg::aoms_merge(
                                        {16'h0, rate_reg}, w_data_reg,
                                        w_strb_reg));
        `AOMS_OFF_CTRL: if (w_strb_reg[0]) cread_next = wr_img[`AOMS_CTRL_CREAD];
        `AOMS_OFF_INT_STAT: if (w_strb_reg[0]) ist_next = ist_reg & ~wr_img[1:0];
        `AOMS_OFF_INT_MASK: if (w_strb_reg[0]) imask_next = wr_img[1:0];
        default: ;
      endcase
    end
    // reads of the result release ready
    if (rd_data_fire || sh.done) begin
      rdy_n_next = 1'b1;
    end
    // period counting in modulator ticks
    if (converting && tick) begin
      cnt_next = cnt_reg + 17'h1;
    end
    if (state_reg == aoms_pkg::AOMS_ST_SETTLE) begin
      set_next = set_reg + 1'b1;
      if (set_reg == SET_W'(SETTLE_CYCLES - 1)) begin
        state_next = aoms_pkg::AOMS_ST_SINGLE;
        cnt_next   = 17'h0;
        div_next   = '0;
        first_next = 1'b1;
      end
    end
    if (conv_done) begin
      result_next = conv_result;
      rdy_n_next  = 1'b0;
      cnt_next    = 17'h0;
      first_next  = 1'b0;
      ist_next[`AOMS_INT_CONV] = 1'b1;
      if (state_reg == aoms_pkg::AOMS_ST_SINGLE) begin
        state_next = aoms_pkg::AOMS_ST_PDOWN;
        mode_next[`AOMS_MODE_HI:`AOMS_MODE_LO] = aoms_pkg::AOMS_MD_PDOWN;
        ist_next[`AOMS_INT_SINGLE] = 1'b1;
      end
    end
    // any restart starts a fresh two-period first result, divider too,
    // otherwise a partial first tick would make the result come early
    if (restart) begin
      rdy_n_next = 1'b1;
      cnt_next   = 17'h0;
      div_next   = '0;
      first_next = 1'b1;
      set_next   = '0;
    end
    if (mode_wr) begin
      unique case (new_mode)
        aoms_pkg::AOMS_MD_CONT:   state_next = aoms_pkg::AOMS_ST_CONT;
        aoms_pkg::AOMS_MD_SINGLE: state_next = aoms_pkg::AOMS_ST_SETTLE;
        aoms_pkg::AOMS_MD_PDOWN:  state_next = aoms_pkg::AOMS_ST_PDOWN;
        default:                  state_next = aoms_pkg::AOMS_ST_IDLE;
      endcase
    end
    mrst_next = restart || !(state_next == aoms_pkg::AOMS_ST_CONT ||
                             state_next == aoms_pkg::AOMS_ST_SINGLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg  <= aoms_pkg::AOMS_ST_CONT;
      mode_reg   <= `AOMS_MODE_RST;
      cfg_reg    <= `AOMS_CFG_RST;
      io_reg     <= `AOMS_IO_RST;
      rate_reg   <= `AOMS_RATE_RST;
      cread_reg  <= `AOMS_CTRL_RST;
      ist_reg    <= 2'h0;
      imask_reg  <= `AOMS_MASK_RST;
      result_reg <= '0;
      rdy_n_reg  <= 1'b1;
      first_reg  <= 1'b1;
      cnt_reg    <= 17'h0;
      set_reg    <= '0;
      div_reg    <= '0;
      mrst_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      mode_reg   <= mode_next;
      cfg_reg    <= cfg_next;
      io_reg     <= io_next;
      rate_reg   <= rate_next;
      cread_reg  <= cread_next;
      ist_reg    <= ist_next;
      imask_reg  <= imask_next;
      result_reg <= result_next;
      rdy_n_reg  <= rdy_n_next;
      first_reg  <= first_next;
      cnt_reg    <= cnt_next;
      set_reg    <= set_next;
      div_reg    <= div_next;
      mrst_reg   <= mrst_next;
    end
  end

  // new results are pushed to the shifter only in continuous read
  assign sh.load = conv_done && cread_reg;
  assign sh.data = conv_result;

  aoms_result_shifter #(.DATA_W(DATA_W)) u_shift (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sh       (sh),
    .ser_clk  (ser_clk),
    .ser_dout (ser_dout)
  );

  // power gating; power-down drops every analog helper
  assign analog_power_en     = state_reg != aoms_pkg::AOMS_ST_PDOWN;
  assign mod_clk_en          = analog_power_en;
  assign excitation_en       = analog_power_en &&
                               |io_reg[`AOMS_IO_EXC_HI:`AOMS_IO_EXC_LO];
  assign burnout_en          = analog_power_en && cfg_reg[`AOMS_CFG_BO];
  assign bias_en             = analog_power_en &&
                               |cfg_reg[`AOMS_CFG_VB_HI:`AOMS_CFG_VB_LO];
  assign clock_output_driver = analog_power_en &&
    mode_reg[`AOMS_CLKSEL_HI:`AOMS_CLKSEL_LO] == `AOMS_CLKSEL_OUT;
  assign channel_sel         = cfg_reg[`AOMS_CFG_CH_HI:`AOMS_CFG_CH_LO];
  assign mod_reset           = mrst_reg;
  assign filter_reset        = mrst_reg;
  assign conv_ready_n        = rdy_n_reg;
  assign irq                 = |(ist_reg & imask_reg);

  // helper: modulator ticks since the last restart or result
  logic [16:0] ticks_a_reg;
  always_ff @(posedge sys_clk) begin
    if (!resetn || restart || conv_done || !converting) begin
      ticks_a_reg <= 17'h0;
    end else if (tick) begin
      ticks_a_reg <= ticks_a_reg + 17'h1;
    end
  end

  reset_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !$past(resetn) |-> mode_reg == `AOMS_MODE_RST &&
      state_reg == aoms_pkg::AOMS_ST_CONT)
    else $error("mode not continuous after reset");
  cont_store_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_done |=> result_reg == $past(conv_result))
    else $error("result not stored");
  ready_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_done |=> !conv_ready_n)
    else $error("ready not low after conversion");
  first_two_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_done && first_reg |->
      ticks_a_reg == {rate_reg, 1'b0} - 17'h1)
    else $error("first result not after two periods");
  next_one_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_done && !first_reg |-> ticks_a_reg == {1'b0, rate_reg} - 17'h1)
    else $error("later result not one period apart");
  settle_wait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $changed(state_reg) && state_reg == aoms_pkg::AOMS_ST_SINGLE |->
      $past(set_reg) == SET_W'(SETTLE_CYCLES - 1))
    else $error("conversion began before settling");
  single_back_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    conv_done && state_reg == aoms_pkg::AOMS_ST_SINGLE |=>
      state_reg == aoms_pkg::AOMS_ST_PDOWN && !conv_ready_n &&
      ist_reg[`AOMS_INT_SINGLE])
    else $error("single did not return to power-down");
  hold_ready_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == aoms_pkg::AOMS_ST_PDOWN && !conv_ready_n && !rd_data_fire &&
      !sh.done && !restart |=> !conv_ready_n && $stable(result_reg))
    else $error("single result not held");
  idle_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == aoms_pkg::AOMS_ST_IDLE |-> mod_reset && filter_reset &&
      !conv_done && mod_clk_en)
    else $error("idle not holding core in reset");
  pdown_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == aoms_pkg::AOMS_ST_PDOWN |-> !analog_power_en &&
      !clock_output_driver && !bias_en && !burnout_en && !excitation_en)
    else $error("circuitry on in power-down");
  mode_wr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    mode_wr |=> conv_ready_n && mod_reset && filter_reset)
    else $error("mode write did not reset core");
  pdown_bus_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == aoms_pkg::AOMS_ST_PDOWN && s_axi_awvalid && s_axi_awready
      |=> aw_have_reg)
    else $error("write refused in power-down");
endmodule
`default_nettype wire

// file: src/aoms_defs.svh
`ifndef AOMS_DEFS_SVH
`define AOMS_DEFS_SVH

// register byte offsets
`define AOMS_OFF_MODE     8'h00
`define AOMS_OFF_CFG      8'h04
`define AOMS_OFF_IO       8'h08
`define AOMS_OFF_DATA     8'h0C
`define AOMS_OFF_STAT     8'h10
`define AOMS_OFF_INT_STAT 8'h14
`define AOMS_OFF_INT_MASK 8'h18
`define AOMS_OFF_RATE     8'h1C
`define AOMS_OFF_CTRL     8'h20

// reset values
`define AOMS_MODE_RST     16'h000A
`define AOMS_CFG_RST      16'h0710
`define AOMS_IO_RST       16'h0000
`define AOMS_RATE_RST     16'h0F00
`define AOMS_CTRL_RST     1'h0
`define AOMS_MASK_RST     2'h0

// field positions
`define AOMS_MODE_HI      15
`define AOMS_MODE_LO      13
`define AOMS_CLKSEL_HI    7
`define AOMS_CLKSEL_LO    6
`define AOMS_CLKSEL_OUT   2'h1
`define AOMS_CFG_VB_HI    15
`define AOMS_CFG_VB_LO    14
`define AOMS_CFG_BO       13
`define AOMS_CFG_CH_HI    2
`define AOMS_CFG_CH_LO    0
`define AOMS_IO_EXC_HI    1
`define AOMS_IO_EXC_LO    0
`define AOMS_INT_CONV     0
`define AOMS_INT_SINGLE   1
`define AOMS_CTRL_CREAD   0

// bus answers
`define AOMS_RESP_OKAY    2'h0
`define AOMS_RESP_SLVERR  2'h2

// timing
`define AOMS_SYS_CLK_HZ   40000000
`define AOMS_HZ_PER_MHZ   1000000
`define AOMS_MOD_CLK_HZ   64000
`define AOMS_OSC_SETTLE_US 1000
`define AOMS_FIRST_PERIODS 2

`endif

// file: src/aoms_pkg.sv
package aoms_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    AOMS_ST_CONT   = 3'h0,
    AOMS_ST_SETTLE = 3'h1,
    AOMS_ST_SINGLE = 3'h2,
    AOMS_ST_IDLE   = 3'h3,
    AOMS_ST_PDOWN  = 3'h4
  } aoms_state_e;

  // operating mode select codes
  typedef enum logic [2:0] {
    AOMS_MD_CONT   = 3'h0,
    AOMS_MD_SINGLE = 3'h1,
    AOMS_MD_IDLE   = 3'h2,
    AOMS_MD_PDOWN  = 3'h3
  } aoms_mode_e;

  // byte-lane merge of a bus write into a 32-bit image
  function automatic logic [31:0] aoms_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // last tick index of a conversion period, first one is doubled
  function automatic logic [16:0] aoms_last_tick(input logic [15:0] rate,
                                                 input logic        first);
    logic [16:0] t;
    t = first ? {rate, 1'b0} : {1'b0, rate};
    return (t == 17'h0) ? 17'h0 : t - 17'h1;
  endfunction

endpackage

// file: src/aoms_shift_if.sv
`timescale 1ns/1ps
`default_nettype none
// result hand-over between the sequencer and the serial shifter
interface aoms_shift_if #(parameter int unsigned DATA_W = 24);
  logic              load;
  logic [DATA_W-1:0] data;
  logic              done;
  modport ctl (output load, output data, input done);
  modport shf (input load, input data, output done);
endinterface
`default_nettype wire

// file: src/aoms_result_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "aoms_defs.svh"
module aoms_result_shifter #(
  parameter int unsigned DATA_W = 24
)(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  // result hand-over
  aoms_shift_if.shf   sh,
  // serial pins
  input  wire logic   ser_clk,
  output logic        ser_dout
);
  localparam int unsigned CNT_W = $clog2(DATA_W + 1);

  logic [DATA_W-1:0] sh_reg,   sh_next;
  logic [CNT_W-1:0]  left_reg, left_next;
  logic              clk_reg,  clk_next;
  logic              done_reg, done_next;

  // data changes on the falling serial edge so the host samples on rising
  always_comb begin
    sh_next   = sh_reg;
    left_next = left_reg;
    clk_next  = ser_clk;
    done_next = 1'b0;
    if (sh.load) begin
      sh_next   = sh.data;
      left_next = CNT_W'(DATA_W);
    end else if (clk_reg && !ser_clk && left_reg != '0) begin
      sh_next   = {sh_reg[DATA_W-2:0], 1'b0};
      left_next = left_reg - 1'b1;
      done_next = (left_reg == CNT_W'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sh_reg   <= '0;
      left_reg <= '0;
      clk_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      left_reg <= left_next;
      clk_reg  <= clk_next;
      done_reg <= done_next;
    end
  end

  assign ser_dout = sh_reg[DATA_W-1];
  assign sh.done  = done_reg; // whole word out counts as a read
endmodule
`default_nettype wire

// file: verification/aoms_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// filter output stand-in; changes every cycle so a stale sample shows
module aoms_core_model (
  // clock
  input  wire logic        sys_clk,
  // filter result
  output logic [23:0]      conv_result
);
  logic [23:0] val_reg = 24'h5A0000;
  // one driver only: the stepping register feeds the port
  always @(posedge sys_clk) val_reg <= val_reg + 24'h000013;
  assign conv_result = val_reg;
endmodule
`default_nettype wire

// file: verification/aoms_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aoms_mode_sequencer_tb_top;
  logic        sys_clk = '0, resetn = '0, ser_clk = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, mod_reset, filter_reset;
  logic        mod_clk_en, analog_power_en, excitation_en, burnout_en;
  logic        bias_en, clock_output_driver, ser_dout, conv_ready_n, irq;
  logic [23:0] conv_result;
  logic [2:0]  channel_sel;
  int          errors = 0, compares = 0, n;
  // short settle so single mode fits the run
  aoms_mode_sequencer #(.SETTLE_CYCLES(20)) u_aoms_mode_sequencer (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conv_result, .mod_reset, .filter_reset,
    .mod_clk_en, .analog_power_en, .excitation_en, .burnout_en, .bias_en,
    .clock_output_driver, .channel_sel, .ser_clk, .ser_dout,
    .conv_ready_n, .irq);
  aoms_core_model u_aoms_core_model (.sys_clk, .conv_result);
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge sys_clk); // let bready fall before the next write
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata; rd_r = s_axi_rresp; s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask
  // bounded wait for ready; count tells the latency
  task wrdy;
    n = 0;
    while (conv_ready_n !== 1'h0 && n < 6000) begin
      @(posedge sys_clk); n++;
    end
  endtask
  task t_cont;
    rd(8'h00); chk(rd_d, 32'h0000000A);
    chk(conv_ready_n, 1'h1);
    wr(8'h1C, 32'h00000002); wr(8'h00, 32'h00000000);
    chk(conv_ready_n, 1'h1);
    wrdy; chk(n >= 2400 && n <= 2600, 1'h1);
    chk(irq, 1'h0);
    wr(8'h18, 32'h00000001); chk(irq, 1'h1);
    rd(8'h0C); chk(conv_ready_n, 1'h1);
    wrdy; chk(n >= 1100 && n <= 1300, 1'h1);
    rd(8'h24); chk(rd_r, 2'h2);
    $display("continuous done");
  endtask
  // host clocks the word out, sampling on each rising serial edge
  task t_cread;
    logic [23:0] w, e;
    wr(8'h20, 32'h00000001); wr(8'h00, 32'h00000000);
    wrdy; e = conv_result - 24'h000013;
    for (int i = 0; i < 24; i++) begin
      ser_clk <= 1'h1; @(posedge sys_clk); w = {w[22:0], ser_dout};
      ser_clk <= 1'h0; @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    chk(w, e);
    chk(conv_ready_n, 1'h1);
    wr(8'h20, 32'h00000000);
    $display("continuous read done");
  endtask
  task t_idle;
    wr(8'h00, 32'h00004040);
    chk({mod_reset, filter_reset, mod_clk_en}, 3'h7);
    chk(clock_output_driver, 1'h1);
    wr(8'h04, 32'h00006713); wr(8'h08, 32'h00000001);
    chk({bias_en, burnout_en, excitation_en, channel_sel}, 6'h3B);
    wr(8'h14, 32'h00000003); repeat (3000) @(posedge sys_clk);
    chk({irq, conv_ready_n}, 2'h1);
    $display("idle done");
  endtask
  task t_pdown;
    wr(8'h00, 32'h00006040);
    chk({analog_power_en, clock_output_driver, bias_en, burnout_en}, 4'h0);
    chk(excitation_en, 1'h0);
    wr(8'h18, 32'h00000002);
    wr(8'h00, 32'h00002040); wrdy;
    chk(n >= 2500 && n <= 2700, 1'h1);
    rd(8'h00); chk(rd_d, 32'h00006040);
    chk({conv_ready_n, analog_power_en}, 2'h0);
    chk(irq, 1'h1);
    $display("single and power-down done");
  endtask
  task end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    t_cont; t_cread; t_idle; t_pdown;
    end_of_test;
  end
  initial begin
    #(25 * 40000);
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
